/* verilog/cpu_flow_ctrl.sv */
// program counter, banked flags, return stack and read-only data window
// assumes execution logic drives one flow op per valid cycle, same clock
`timescale 1ns/1ns
module cpu_flow_ctrl (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  // flow control from execution logic
  input  wire logic                              op_valid,
  input  wire flow_ctrl_pkg::flow_op_t           flow_op,
  input  wire logic [flow_ctrl_pkg::PC_W-1:0]    target,
  input  wire logic [7:0]                        branch_offset,
  // flag updates from execution logic
  input  wire flow_ctrl_pkg::flag_op_t           flag_op,
  input  wire logic                              alu_carry,
  input  wire logic [7:0]                        alu_result,
  input  wire logic                              tested_bit,
  input  wire logic                              rotl_msb,
  // data space access
  input  wire logic                              data_wr,
  input  wire logic                              data_rd,
  input  wire logic                              bit_op,
  input  wire logic [7:0]                        data_addr,
  input  wire logic [7:0]                        data_wdata,
  // program counter, mode, flags and stack depth
  output logic      [flow_ctrl_pkg::PC_W-1:0]    pc,
  output flow_ctrl_pkg::exec_mode_t              mode,
  output logic                                   carry,
  output logic                                   zero,
  output logic      [flow_ctrl_pkg::DEPTH_W-1:0] stack_depth,
  // window read toward program memory
  output logic                                   window_rd,
  output logic      [flow_ctrl_pkg::PC_W-1:0]    window_addr
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [flow_ctrl_pkg::PC_W-1:0]    next_pc;
  flow_ctrl_pkg::exec_mode_t         next_mode;
  flow_ctrl_pkg::exec_mode_t         saved_mode [2];
  flow_ctrl_pkg::exec_mode_t         next_saved [2];
  logic [2:0]                        carry_bank;
  logic [2:0]                        zero_bank;
  logic [2:0]                        next_carry_bank;
  logic [2:0]                        next_zero_bank;
  logic                              next_carry;
  logic                              next_zero;
  logic [flow_ctrl_pkg::PAGE_W-1:0]  window_page;
  logic [flow_ctrl_pkg::PAGE_W-1:0]  next_window_page;
  logic                              next_window_rd;
  logic [flow_ctrl_pkg::PC_W-1:0]    next_window_addr;
  logic                              push;
  logic                              pop;
  logic [flow_ctrl_pkg::PC_W-1:0]    stack_top;
  logic [flow_ctrl_pkg::DEPTH_W-1:0] depth;
  logic [flow_ctrl_pkg::DEPTH_W-1:0] next_stack_depth;
  logic [flow_ctrl_pkg::PC_W-1:0]    seq_pc;
  logic [flow_ctrl_pkg::PC_W-1:0]    branch_sum;
  logic                              in_window;
  logic                              page_hit;

  // ***************************************************************
  // return stack
  // ***************************************************************
  return_stack u_stack (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .push      (push),
    .pop       (pop),
    .push_data (seq_pc),
    .top       (stack_top),
    .depth     (depth)
  );

  // ***************************************************************
  // program counter sequencing
  // ***************************************************************
  assign seq_pc = pc + flow_ctrl_pkg::PC_STEP;

  // sign-extended offset through the adder; wraps within 4 kbyte space
  assign branch_sum = seq_pc + {{(flow_ctrl_pkg::PC_W-8){branch_offset[7]}}, branch_offset};

  always_comb begin
    next_pc = pc;
    push    = 1'b0;
    pop     = 1'b0;
    if (op_valid) begin
      case (flow_op)
        flow_ctrl_pkg::FLOW_NEXT: begin
          next_pc = seq_pc;
        end
        flow_ctrl_pkg::FLOW_JUMP: begin
          next_pc = target;
        end
        flow_ctrl_pkg::FLOW_CALL: begin
          next_pc = target;
          push    = 1'b1;
        end
        flow_ctrl_pkg::FLOW_BRANCH: begin
          next_pc = branch_sum;
        end
        flow_ctrl_pkg::FLOW_SUB_EXIT,
        flow_ctrl_pkg::FLOW_INT_EXIT: begin
          // empty stack: no pop, just fall through to the next instruction
          if (depth != flow_ctrl_pkg::DEPTH_EMPTY) begin
            next_pc = stack_top;
            pop     = 1'b1;
          end else begin
            next_pc = seq_pc;
          end
        end
        flow_ctrl_pkg::FLOW_IRQ_ENTRY,
        flow_ctrl_pkg::FLOW_NMI_ENTRY: begin
          // pc plus one is pushed as for a call; execution logic lines pc up first
          next_pc = target;
          push    = 1'b1;
        end
        default: begin
          next_pc = pc;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pc <= flow_ctrl_pkg::RESET_VECTOR;
    else pc <= next_pc;
  end

  // ***************************************************************
  // stack depth view
  // ***************************************************************
  // local copy of the stack's own counter, so the port comes from a flop here
  always_comb begin
    next_stack_depth = stack_depth;
    if (push) begin
      if (stack_depth != flow_ctrl_pkg::DEPTH_FULL) begin
        next_stack_depth = stack_depth + flow_ctrl_pkg::DEPTH_STEP;
      end
    end else if (pop) begin
      next_stack_depth = stack_depth - flow_ctrl_pkg::DEPTH_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) stack_depth <= flow_ctrl_pkg::DEPTH_EMPTY;
    else stack_depth <= next_stack_depth;
  end

  // ***************************************************************
  // mode tracking
  // ***************************************************************
  // two saved entries cover the deepest legal nesting normal, irq, nmi
  always_comb begin
    next_mode     = mode;
    next_saved[0] = saved_mode[0];
    next_saved[1] = saved_mode[1];
    if (op_valid) begin
      case (flow_op)
        flow_ctrl_pkg::FLOW_IRQ_ENTRY: begin
          next_mode     = flow_ctrl_pkg::MODE_IRQ;
          next_saved[0] = mode;
          next_saved[1] = saved_mode[0];
        end
        flow_ctrl_pkg::FLOW_NMI_ENTRY: begin
          next_mode     = flow_ctrl_pkg::MODE_NMI;
          next_saved[0] = mode;
          next_saved[1] = saved_mode[0];
        end
        flow_ctrl_pkg::FLOW_INT_EXIT: begin
          next_mode     = saved_mode[0];
          next_saved[0] = saved_mode[1];
          next_saved[1] = flow_ctrl_pkg::MODE_NORMAL;
        end
        default: begin
          next_mode = mode;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode          <= flow_ctrl_pkg::MODE_NMI;
      saved_mode[0] <= flow_ctrl_pkg::MODE_NORMAL;
      saved_mode[1] <= flow_ctrl_pkg::MODE_NORMAL;
    end else begin
      mode          <= next_mode;
      saved_mode[0] <= next_saved[0];
      saved_mode[1] <= next_saved[1];
    end
  end

  // ***************************************************************
  // banked carry and zero flags
  // ***************************************************************
  // bank index is the mode code; only the current bank is written
  always_comb begin
    next_carry_bank = carry_bank;
    next_zero_bank  = zero_bank;
    case (flag_op)
      flow_ctrl_pkg::FLAG_ARITH: begin
        next_carry_bank[mode] = alu_carry;
        next_zero_bank[mode]  = (alu_result == 8'h00);
      end
      flow_ctrl_pkg::FLAG_LOGIC: begin
        next_zero_bank[mode] = (alu_result == 8'h00);
      end
      flow_ctrl_pkg::FLAG_BITTST: begin
        next_carry_bank[mode] = tested_bit;
      end
      flow_ctrl_pkg::FLAG_ROTL: begin
        next_carry_bank[mode] = rotl_msb;
        next_zero_bank[mode]  = (alu_result == 8'h00);
      end
      default: begin
        next_carry_bank = carry_bank;
      end
    endcase
    next_carry = next_carry_bank[next_mode];
    next_zero  = next_zero_bank[next_mode];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_bank <= 3'h0;
      zero_bank  <= 3'h0;
      carry      <= 1'b0;
      zero       <= 1'b0;
    end else begin
      carry_bank <= next_carry_bank;
      zero_bank  <= next_zero_bank;
      carry      <= next_carry;
      zero       <= next_zero;
    end
  end

  // ***************************************************************
  // data window page register
  // ***************************************************************
  assign page_hit  = (data_addr == flow_ctrl_pkg::PAGE_REG_ADDR);
  assign in_window = (data_addr >= flow_ctrl_pkg::WINDOW_FIRST) &&
                     (data_addr <= flow_ctrl_pkg::WINDOW_LAST);

  always_comb begin
    next_window_page = window_page;
    // bit operations are a read-modify-write, which this register cannot do
    if (data_wr && page_hit && !bit_op) begin
      next_window_page = data_wdata[flow_ctrl_pkg::PAGE_W-1:0];
    end
  end

  // deliberately no reset: contents stay undefined until software writes
  always_ff @(posedge sys_clk) begin
    window_page <= next_window_page;
  end

  // ***************************************************************
  // window read toward program memory
  // ***************************************************************
  always_comb begin
    next_window_rd   = data_rd && in_window;
    next_window_addr = window_addr;
    if (data_rd && in_window) begin
      next_window_addr = {window_page, data_addr[flow_ctrl_pkg::LOW_W-1:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      window_rd   <= 1'b0;
      window_addr <= flow_ctrl_pkg::STACK_RESET;
    end else begin
      window_rd   <= next_window_rd;
      window_addr <= next_window_addr;
    end
  end

endmodule

/* verilog/flow_ctrl_pkg.sv */
// shared constants and types for the core flow, flag and window control
// assumes a single sys_clk domain and the companion return stack module
package flow_ctrl_pkg;

  // ***************************************************************
  // widths and counts
  // ***************************************************************
  localparam int PC_W         = 12;
  localparam int PAGE_W       = 6;
  localparam int LOW_W        = 6;
  localparam int STACK_LEVELS = 6;
  localparam int DEPTH_W      = 3;

  // ***************************************************************
  // data space map
  // ***************************************************************
  localparam logic [7:0] WINDOW_FIRST   = 8'h40;
  localparam logic [7:0] WINDOW_LAST    = 8'h7F;
  localparam logic [7:0] PAGE_REG_ADDR  = 8'hC9;

  // ***************************************************************
  // reset values, steps and depth limits
  // ***************************************************************
  localparam logic [PC_W-1:0]    RESET_VECTOR = 12'h0FFE;
  localparam logic [PC_W-1:0]    PC_STEP      = 12'h001;
  localparam logic [PC_W-1:0]    STACK_RESET  = 12'h000;
  localparam logic [DEPTH_W-1:0] DEPTH_EMPTY  = 3'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL   = 3'h6;
  localparam logic [DEPTH_W-1:0] DEPTH_STEP   = 3'h1;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_IRQ    = 2'b01,
    MODE_NMI    = 2'b10
  } exec_mode_t;

  typedef enum logic [2:0] {
    FLOW_NEXT        = 3'b000,
    FLOW_JUMP        = 3'b001,
    FLOW_CALL        = 3'b010,
    FLOW_BRANCH      = 3'b011,
    FLOW_SUB_EXIT    = 3'b100,
    FLOW_INT_EXIT    = 3'b101,
    FLOW_IRQ_ENTRY   = 3'b110,
    FLOW_NMI_ENTRY   = 3'b111
  } flow_op_t;

  typedef enum logic [2:0] {
    FLAG_NONE   = 3'b000,
    FLAG_ARITH  = 3'b001,
    FLAG_LOGIC  = 3'b010,
    FLAG_BITTST = 3'b011,
    FLAG_ROTL   = 3'b100
  } flag_op_t;

endpackage

/* verilog/return_stack.sv */
// six level shift-register return stack with no visible pointer
// assumes push and pop never arrive together; push wins if they do
`timescale 1ns/1ns
module return_stack (
  // clock and reset
  input  wire logic                               sys_clk,
  input  wire logic                               rst_n,
  // control
  input  wire logic                               push,
  input  wire logic                               pop,
  input  wire logic [flow_ctrl_pkg::PC_W-1:0]     push_data,
  // state
  output logic      [flow_ctrl_pkg::PC_W-1:0]     top,
  output logic      [flow_ctrl_pkg::DEPTH_W-1:0]  depth
);

  // ***************************************************************
  // storage levels
  // ***************************************************************
  logic [flow_ctrl_pkg::PC_W-1:0]    level      [flow_ctrl_pkg::STACK_LEVELS];
  logic [flow_ctrl_pkg::PC_W-1:0]    next_level [flow_ctrl_pkg::STACK_LEVELS];
  logic [flow_ctrl_pkg::DEPTH_W-1:0] next_depth;

  genvar gi;
  generate
    for (gi = 0; gi < flow_ctrl_pkg::STACK_LEVELS; gi++) begin : g_lvl
      logic [flow_ctrl_pkg::PC_W-1:0] above;
      logic [flow_ctrl_pkg::PC_W-1:0] below;
      // end levels pick their neighbour at elaboration, so no index leaves the array
      if (gi == 0) begin : g_first
        assign above = push_data;
      end else begin : g_inner
        assign above = level[gi-1];
      end
      if (gi == flow_ctrl_pkg::STACK_LEVELS - 1) begin : g_last
        assign below = level[gi];
      end else begin : g_upper
        assign below = level[gi+1];
      end
      always_comb begin
        next_level[gi] = level[gi];
        if (push) begin
          // deepest level simply falls off the end
          next_level[gi] = above;
        end else if (pop) begin
          next_level[gi] = below;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) level[gi] <= flow_ctrl_pkg::STACK_RESET;
        else level[gi] <= next_level[gi];
      end
    end
  endgenerate

  // ***************************************************************
  // depth tracking, saturating both ways
  // ***************************************************************
  always_comb begin
    next_depth = depth;
    if (push) begin
      if (depth != flow_ctrl_pkg::DEPTH_FULL) next_depth = depth + flow_ctrl_pkg::DEPTH_STEP;
    end else if (pop) begin
      if (depth != flow_ctrl_pkg::DEPTH_EMPTY) next_depth = depth - flow_ctrl_pkg::DEPTH_STEP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) depth <= flow_ctrl_pkg::DEPTH_EMPTY;
    else depth <= next_depth;
  end

  assign top = level[0];

endmodule

/* bench/cpu_flow_ctrl_asserts.sv */
// concurrent checks on the flow, flag and window control ports
// assumes binding onto cpu_flow_ctrl; sees its ports only
`timescale 1ns/1ns
module cpu_flow_ctrl_asserts (
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  // inputs watched
  input wire logic                       op_valid,
  input wire flow_ctrl_pkg::flow_op_t    flow_op,
  input wire logic [11:0]                target,
  input wire logic [7:0]                 branch_offset,
  input wire flow_ctrl_pkg::flag_op_t    flag_op,
  input wire logic                       alu_carry,
  input wire logic [7:0]                 alu_result,
  input wire logic                       data_rd,
  input wire logic [7:0]                 data_addr,
  // outputs watched
  input wire logic [11:0]                pc,
  input wire flow_ctrl_pkg::exec_mode_t  mode,
  input wire logic                       carry,
  input wire logic                       zero,
  input wire logic [2:0]                 stack_depth,
  input wire logic                       window_rd,
  input wire logic [11:0]                window_addr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ***************************************************************
  // properties
  // ***************************************************************
  AST_WIN_PULSE: assert property (##1 window_rd == $past(data_rd && data_addr >= 8'h40 && data_addr <= 8'h7F))
    else $error("window pulse does not match a window access");
  AST_WIN_LOW: assert property (data_rd && data_addr[7:6] == 2'b01 |=> window_addr[5:0] == $past(data_addr[5:0]))
    else $error("window low address bits wrong");
  AST_PC_STEP: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_NEXT |=> pc == $past(pc) + 12'h001)
    else $error("pc did not step by one");
  AST_JUMP: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_JUMP |=> pc == $past(target))
    else $error("jump target not loaded");
  AST_BRANCH: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_BRANCH |=> pc == $past(pc) + 12'h001 + {{4{$past(branch_offset[7])}}, $past(branch_offset)})
    else $error("branch target wrong");
  AST_PUSH: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_CALL && stack_depth < 3'h6 |=> stack_depth == $past(stack_depth) + 3'h1)
    else $error("call did not deepen stack");
  AST_SATURATE: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_CALL && stack_depth == 3'h6 |=> stack_depth == 3'h6)
    else $error("full stack depth changed on call");
  AST_EMPTY_EXIT: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_SUB_EXIT && stack_depth == 3'h0 |=> pc == $past(pc) + 12'h001 && stack_depth == 3'h0)
    else $error("return on empty stack misbehaved");
  AST_ARITH: assert property (flag_op == flow_ctrl_pkg::FLAG_ARITH && !op_valid |=> carry == $past(alu_carry) && zero == ($past(alu_result) == 8'h00))
    else $error("arithmetic flags wrong");
  AST_IRQ_MODE: assert property (op_valid && flow_op == flow_ctrl_pkg::FLOW_IRQ_ENTRY |=> mode == flow_ctrl_pkg::MODE_IRQ)
    else $error("interrupt entry did not switch mode");
  AST_DEPTH_MAX: assert property (stack_depth <= 3'h6)
    else $error("stack depth above six");
endmodule
bind cpu_flow_ctrl cpu_flow_ctrl_asserts i_cpu_flow_ctrl_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
  .op_valid(op_valid), .flow_op(flow_op), .target(target), .branch_offset(branch_offset),
  .flag_op(flag_op), .alu_carry(alu_carry), .alu_result(alu_result), .data_rd(data_rd),
  .data_addr(data_addr), .pc(pc), .mode(mode), .carry(carry), .zero(zero),
  .stack_depth(stack_depth), .window_rd(window_rd), .window_addr(window_addr));

/* bench/prog_mem_model.sv */
// program memory answering window reads with a byte pattern
// assumes window_rd is a one-cycle pulse on sys_clk
`timescale 1ns/1ns
module prog_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        window_rd,
  input  wire logic [11:0] window_addr,
  output logic      [7:0]  rom_byte
);
  // outside a read the bus is not held, so it toggles instead
  initial rom_byte = 8'h00;
  always @(posedge sys_clk) rom_byte <= window_rd ? window_addr[7:0] ^ window_addr[11:4] : ~rom_byte;
endmodule

/* bench/testbench.sv */
// self-checking bench for cpu_flow_ctrl with program memory model
// assumes 50 MHz sys_clk, inputs driven at the falling edge
`timescale 1ns/1ns
module testbench;
  logic sys_clk, rst_n, op_valid, alu_carry, tested_bit, rotl_msb, data_wr, data_rd, bit_op;
  logic carry, zero, window_rd;
  logic [11:0] target, pc, window_addr;
  logic [7:0] branch_offset, alu_result, data_addr, data_wdata, rom_byte, pg, ad;
  logic [2:0] stack_depth;
  flow_ctrl_pkg::flow_op_t flow_op;
  flow_ctrl_pkg::flag_op_t flag_op;
  flow_ctrl_pkg::exec_mode_t mode;
  logic [11:0] win_q[$];
  logic [7:0] byte_exp;
  logic byte_due = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  cpu_flow_ctrl i_cpu_flow_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid),
    .flow_op(flow_op), .target(target), .branch_offset(branch_offset), .flag_op(flag_op),
    .alu_carry(alu_carry), .alu_result(alu_result), .tested_bit(tested_bit),
    .rotl_msb(rotl_msb), .data_wr(data_wr), .data_rd(data_rd), .bit_op(bit_op),
    .data_addr(data_addr), .data_wdata(data_wdata), .pc(pc), .mode(mode), .carry(carry),
    .zero(zero), .stack_depth(stack_depth), .window_rd(window_rd), .window_addr(window_addr));
  prog_mem_model i_prog_mem_model (.sys_clk(sys_clk), .window_rd(window_rd),
    .window_addr(window_addr), .rom_byte(rom_byte));
  // ***************************************************************
  // compare and drive tasks
  // ***************************************************************
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_win(input logic [11:0] got);
    logic [11:0] exp;
    exp = (win_q.size() == 0) ? 12'hxxx : win_q.pop_front();
    check(got, exp);
    // program memory answers one edge later with its pattern for that address
    byte_due = (exp !== 12'hxxx);
    byte_exp = exp[7:0] ^ exp[11:4];
  endtask
  task automatic st(input logic [11:0] p, input logic [1:0] m, input logic [2:0] d,
                    input logic c, input logic z);
    check(pc, p);
    check({10'h000, mode}, {10'h000, m});
    check({9'h000, stack_depth}, {9'h000, d});
    check({10'h000, carry, zero}, {10'h000, c, z});
  endtask
  task automatic flow(input flow_ctrl_pkg::flow_op_t f, input logic [11:0] t, input logic [7:0] o);
    @(negedge sys_clk);
    op_valid = 1'b1;
    flow_op = f;
    target = t;
    branch_offset = o;
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask
  task automatic flag(input flow_ctrl_pkg::flag_op_t f, input logic c, input logic [7:0] r,
                      input logic b);
    @(negedge sys_clk);
    flag_op = f;
    alu_carry = c;
    alu_result = r;
    tested_bit = b;
    rotl_msb = c;
    @(negedge sys_clk);
    flag_op = flow_ctrl_pkg::FLAG_NONE;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(negedge sys_clk);
    data_wr = 1'b1;
    data_addr = a;
    data_wdata = d;
    bit_op = b;
    @(negedge sys_clk);
    data_wr = 1'b0;
    bit_op = 1'b0;
  endtask
  // expected window address is queued when the read is issued
  task automatic rd(input logic [7:0] a, input logic [11:0] exp);
    @(negedge sys_clk);
    data_rd = 1'b1;
    data_addr = a;
    if (a[7:6] == 2'b01) win_q.push_back(exp);
    @(negedge sys_clk);
    data_rd = 1'b0;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ***************************************************************
  // clock, watcher, watchdog
  // ***************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (byte_due) check({4'h0, rom_byte}, {4'h0, byte_exp});
    byte_due = 1'b0;
    if (window_rd !== 1'b0) check_win(window_addr);
  end
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {rst_n, op_valid, alu_carry, tested_bit, rotl_msb, data_wr, data_rd, bit_op} = 8'h00;
    {target, branch_offset, alu_result, data_addr, data_wdata} = 44'h0;
    flow_op = flow_ctrl_pkg::FLOW_NEXT;
    flag_op = flow_ctrl_pkg::FLAG_NONE;
    void'($urandom(76));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    st(12'h0FFE, flow_ctrl_pkg::MODE_NMI, 3'h0, 1'b0, 1'b0);
    flow(flow_ctrl_pkg::FLOW_NEXT, 12'h000, 8'h00);
    flow(flow_ctrl_pkg::FLOW_NEXT, 12'h000, 8'h00);
    check(pc, 12'h000);
    flag(flow_ctrl_pkg::FLAG_ARITH, 1'b1, 8'h00, 1'b0);
    st(12'h000, flow_ctrl_pkg::MODE_NMI, 3'h0, 1'b1, 1'b1);
    flow(flow_ctrl_pkg::FLOW_INT_EXIT, 12'h000, 8'h00);
    st(12'h001, flow_ctrl_pkg::MODE_NORMAL, 3'h0, 1'b0, 1'b0);
    flag(flow_ctrl_pkg::FLAG_LOGIC, 1'b1, 8'h05, 1'b0);
    check({11'h000, zero}, 12'h000);
    flag(flow_ctrl_pkg::FLAG_ARITH, 1'b1, 8'h03, 1'b0);
    flow(flow_ctrl_pkg::FLOW_IRQ_ENTRY, 12'h010, 8'h00);
    st(12'h010, flow_ctrl_pkg::MODE_IRQ, 3'h1, 1'b0, 1'b0);
    flag(flow_ctrl_pkg::FLAG_BITTST, 1'b0, 8'h01, 1'b1);
    check({11'h000, carry}, 12'h001);
    flag(flow_ctrl_pkg::FLAG_ROTL, 1'b0, 8'h00, 1'b1);
    flow(flow_ctrl_pkg::FLOW_INT_EXIT, 12'h000, 8'h00);
    st(12'h002, flow_ctrl_pkg::MODE_NORMAL, 3'h0, 1'b1, 1'b0);
    flow(flow_ctrl_pkg::FLOW_NMI_ENTRY, 12'h020, 8'h00);
    st(12'h020, flow_ctrl_pkg::MODE_NMI, 3'h1, 1'b1, 1'b1);
    flow(flow_ctrl_pkg::FLOW_INT_EXIT, 12'h000, 8'h00);
    // nested entries: normal, then irq, then nmi, unwound in turn
    flow(flow_ctrl_pkg::FLOW_IRQ_ENTRY, 12'h030, 8'h00);
    flow(flow_ctrl_pkg::FLOW_NMI_ENTRY, 12'h040, 8'h00);
    st(12'h040, flow_ctrl_pkg::MODE_NMI, 3'h2, 1'b1, 1'b1);
    flow(flow_ctrl_pkg::FLOW_INT_EXIT, 12'h000, 8'h00);
    st(12'h031, flow_ctrl_pkg::MODE_IRQ, 3'h1, 1'b0, 1'b1);
    flow(flow_ctrl_pkg::FLOW_INT_EXIT, 12'h000, 8'h00);
    st(12'h004, flow_ctrl_pkg::MODE_NORMAL, 3'h0, 1'b1, 1'b0);
    flow(flow_ctrl_pkg::FLOW_JUMP, 12'h100, 8'h00);
    flow(flow_ctrl_pkg::FLOW_BRANCH, 12'h000, 8'hFE);
    check(pc, 12'h0FF);
    flow(flow_ctrl_pkg::FLOW_BRANCH, 12'h000, 8'h10);
    check(pc, 12'h110);
    for (int i = 0; i < 7; i++) begin
      flow(flow_ctrl_pkg::FLOW_CALL, 12'h200 + 12'(i), 8'h00);
      check({9'h000, stack_depth}, (i < 6) ? 12'(i + 1) : 12'h006);
    end
    for (int i = 0; i < 6; i++) begin
      flow(flow_ctrl_pkg::FLOW_SUB_EXIT, 12'h000, 8'h00);
      check(pc, 12'h206 - 12'(i));
    end
    flow(flow_ctrl_pkg::FLOW_SUB_EXIT, 12'h000, 8'h00);
    st(12'h202, flow_ctrl_pkg::MODE_NORMAL, 3'h0, 1'b1, 1'b0);
    // the page register has no reset value, so it is written first
    wr(8'hC9, 8'h28, 1'b0);
    rd(8'h59, 12'hA19);
    wr(8'hC9, 8'hE8, 1'b0);
    rd(8'h40, 12'hA00);
    wr(8'hC9, 8'h3F, 1'b1);
    rd(8'h7F, 12'hA3F);
    rd(8'h3F, 12'h000);
    rd(8'h80, 12'h000);
    rd(8'hC9, 12'h000);
    for (int i = 0; i < 8; i++) begin
      pg = 8'($urandom);
      ad = 8'h40 | (8'($urandom) & 8'h3F);
      wr(8'hC9, pg, 1'b0);
      rd(ad, {pg[5:0], ad[5:0]});
    end
    // a second reset mid-run brings back the vector and nmi mode
    @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    st(12'h0FFE, flow_ctrl_pkg::MODE_NMI, 3'h0, 1'b0, 1'b0);
    repeat (3) @(negedge sys_clk);
    check(12'(win_q.size()), 12'h000);
    close_out();
  end
endmodule
